/* File: verilog/vector_map_pkg.sv */
/*
 Constants, source table and carrier types for the interrupt vector mapping block.
 Assumes a single 20 MHz clock domain and peripherals that pulse their event lines.
*/
`default_nettype none
package vector_map_pkg;
    localparam int unsigned N_SRC        = 16;
    localparam int unsigned IDX_W        = 4;
    localparam logic [23:0] RESET_PC     = 24'h000000;
    localparam logic [23:0] START_WORD   = 24'h000002;
    localparam logic [23:0] VEC_END      = 24'h000200;
    localparam logic [23:0] VEC_BASE     = 24'h000004;
    localparam logic [23:0] PC_STEP      = 24'h000002;
    localparam logic [6:0]  IRQ_OFFSET   = 7'h08;
    localparam logic [2:0]  PRIO_RESET   = 3'h4;
    localparam logic [2:0]  PRIO_OFF     = 3'h0;

    typedef struct packed {
        logic [6:0] vec_num;
        logic [6:0] irq_num;
        logic [1:0] word;
        logic [3:0] bit_pos;
        logic [3:0] prio_word;
        logic [3:0] prio_lsb;
        logic       can_only;
        logic       mc_only;
    } src_info_t;

    // Mostly vector order, but the last entry sits out of order, so arbitration
    // compares vector numbers rather than trusting the index
    localparam src_info_t SRC_TABLE [N_SRC] = '{
        '{7'd8,  7'd0,  2'd0, 4'd0,  4'd0,  4'd0, 1'b0, 1'b0},
        '{7'd10, 7'd2,  2'd0, 4'd2,  4'd0,  4'd8, 1'b0, 1'b0},
        '{7'd12, 7'd4,  2'd0, 4'd4,  4'd1,  4'd0, 1'b0, 1'b0},
        '{7'd24, 7'd16, 2'd1, 4'd0,  4'd4,  4'd0, 1'b0, 1'b0},
        '{7'd26, 7'd18, 2'd1, 4'd2,  4'd4,  4'd8, 1'b0, 1'b0},
        '{7'd32, 7'd24, 2'd1, 4'd8,  4'd6,  4'd0, 1'b0, 1'b0},
        '{7'd37, 7'd29, 2'd1, 4'd13, 4'd7,  4'd4, 1'b0, 1'b0},
        '{7'd39, 7'd31, 2'd1, 4'd15, 4'd7,  4'd12, 1'b0, 1'b0},
        '{7'd41, 7'd33, 2'd2, 4'd1,  4'd8,  4'd4, 1'b0, 1'b0},
        '{7'd42, 7'd34, 2'd2, 4'd2,  4'd8,  4'd8, 1'b1, 1'b0},
        '{7'd43, 7'd35, 2'd2, 4'd3,  4'd8,  4'd12, 1'b1, 1'b0},
        '{7'd46, 7'd38, 2'd2, 4'd6,  4'd9,  4'd8, 1'b0, 1'b0},
        '{7'd57, 7'd49, 2'd3, 4'd1,  4'd12, 4'd4, 1'b0, 1'b0},
        '{7'd58, 7'd50, 2'd3, 4'd2,  4'd12, 4'd8, 1'b0, 1'b0},
        '{7'd65, 7'd57, 2'd3, 4'd9,  4'd14, 4'd4, 1'b0, 1'b1},
        '{7'd28, 7'd20, 2'd1, 4'd4,  4'd5,  4'd0, 1'b0, 1'b0}
    };

    typedef struct packed {
        logic        valid;
        logic [2:0]  level;
        logic [6:0]  vec_num;
        logic [6:0]  irq_num;
        logic [23:0] vec_addr;
    } irq_req_t;

    typedef struct packed {
        logic        set;
        logic [3:0]  idx;
    } src_sel_t;
endpackage
`default_nettype wire

/* File: verilog/prio_pick.sv */
/*
 Combinational pick of the highest-priority pending source.
 Assumes each table entry carries a unique vector number.
*/
`default_nettype none
module prio_pick
    import vector_map_pkg::*;
(
    input  wire logic [N_SRC-1:0] pend,
    input  wire logic [3*N_SRC-1:0] level,
    output logic                  found,
    output logic [IDX_W-1:0]      idx,
    output logic [2:0]            best
);
    logic [6:0]                   best_vec;

    always_comb begin
        found    = 1'b0;
        idx      = '0;
        best     = PRIO_OFF;
        best_vec = '1;
        // Ties compare vector numbers, since table index is not vector order everywhere
        for (int i = 0; i < N_SRC; i++) begin
            if (pend[i] && level[3*i +: 3] != PRIO_OFF &&
                (level[3*i +: 3] > best ||
                 (level[3*i +: 3] == best && SRC_TABLE[i].vec_num < best_vec))) begin
                found    = 1'b1;
                idx      = IDX_W'(i);
                best     = level[3*i +: 3];
                best_vec = SRC_TABLE[i].vec_num;
            end
        end
    end
endmodule // prio_pick
`default_nettype wire

/* File: verilog/vector_map.sv */
/*
 Interrupt vector mapping: flag and enable words and per-source priority levels for the mapped
 sources, arbitration, and vector address to the core; reset fetch address.
 Assumes event inputs are synchronous one-cycle pulses and software accesses
 arrive as plain strobes on the clk domain.
*/
`default_nettype none
module vector_map
    import vector_map_pkg::*;
#(
    parameter bit HAS_CAN = 1'b1,
    parameter bit HAS_MC  = 1'b1
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic [N_SRC-1:0]  src_evt,
    input  wire logic              flag_wr,
    input  wire logic [1:0]        flag_wr_word,
    input  wire logic [15:0]       flag_wr_data,
    input  wire logic              enable_wr,
    input  wire logic [1:0]        enable_wr_word,
    input  wire logic [15:0]       enable_wr_data,
    input  wire logic              prio_wr,
    input  wire logic [3:0]        prio_wr_idx,
    input  wire logic [2:0]        prio_wr_level,
    input  wire logic              irq_ack,
    input  wire logic              fetch_step,
    input  wire logic              fetch_back,
    input  wire logic              fetch_load,
    input  wire logic [23:0]       fetch_target,
    output logic [15:0]            irq_flag_word_0,
    output logic [15:0]            irq_flag_word_1,
    output logic [15:0]            irq_flag_word_2,
    output logic [15:0]            irq_flag_word_3,
    output logic [15:0]            irq_enable_word_0,
    output logic [15:0]            irq_enable_word_1,
    output logic [15:0]            irq_enable_word_2,
    output logic [15:0]            irq_enable_word_3,
    output irq_req_t               irq_req,
    output logic [23:0]            program_counter,
    output logic                   fetch_upper,
    output logic                   code_in_vectors
);
    logic [N_SRC-1:0]   flag_reg;
    logic [N_SRC-1:0]   enable_reg;
    logic [3*N_SRC-1:0] level_reg;
    logic [N_SRC-1:0]   fitted;
    logic [N_SRC-1:0]   pend;
    logic               found;
    logic [IDX_W-1:0]   win;
    logic [2:0]         win_level;
    logic [23:0]        pc_next;
    logic [IDX_W-1:0]   shown_idx;

    // Sources absent from this variant have flag, enable and pending tied off; their level stays writable
    genvar g;
    generate
        for (g = 0; g < N_SRC; g++) begin : g_src
            assign fitted[g] = !(SRC_TABLE[g].can_only && !HAS_CAN) &&
                               !(SRC_TABLE[g].mc_only && !HAS_MC);
            assign pend[g] = fitted[g] && flag_reg[g] && enable_reg[g];

            // Hardware set wins over a software clear in the same cycle
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flag_reg[g] <= 1'b0;
                end else if (fitted[g] && src_evt[g]) begin
                    flag_reg[g] <= 1'b1;
                end else if (!fitted[g]) begin
                    flag_reg[g] <= 1'b0;
                end else if (flag_wr && flag_wr_word == SRC_TABLE[g].word) begin
                    flag_reg[g] <= flag_wr_data[SRC_TABLE[g].bit_pos];
                end else if (irq_ack && irq_req.valid && shown_idx == IDX_W'(g)) begin
                    flag_reg[g] <= 1'b0;
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    enable_reg[g] <= 1'b0;
                end else if (enable_wr && enable_wr_word == SRC_TABLE[g].word) begin
                    enable_reg[g] <= fitted[g] && enable_wr_data[SRC_TABLE[g].bit_pos];
                end
            end

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    level_reg[3*g +: 3] <= PRIO_RESET;
                end else if (prio_wr && prio_wr_idx == IDX_W'(g)) begin
                    level_reg[3*g +: 3] <= prio_wr_level;
                end
            end
        end
    endgenerate

    prio_pick u_pick (
        .pend  (pend),
        .level (level_reg),
        .found (found),
        .idx   (win),
        .best  (win_level)
    );

    // Flag and enable words mirror the bit layout; reserved bits read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_flag_word_0   <= 16'h0000;
            irq_flag_word_1   <= 16'h0000;
            irq_flag_word_2   <= 16'h0000;
            irq_flag_word_3   <= 16'h0000;
            irq_enable_word_0 <= 16'h0000;
            irq_enable_word_1 <= 16'h0000;
            irq_enable_word_2 <= 16'h0000;
            irq_enable_word_3 <= 16'h0000;
        end else begin
            irq_flag_word_0   <= 16'h0000;
            irq_flag_word_1   <= 16'h0000;
            irq_flag_word_2   <= 16'h0000;
            irq_flag_word_3   <= 16'h0000;
            irq_enable_word_0 <= 16'h0000;
            irq_enable_word_1 <= 16'h0000;
            irq_enable_word_2 <= 16'h0000;
            irq_enable_word_3 <= 16'h0000;
            for (int i = 0; i < N_SRC; i++) begin
                case (SRC_TABLE[i].word)
                    2'd0: begin
                        irq_flag_word_0[SRC_TABLE[i].bit_pos]   <= flag_reg[i];
                        irq_enable_word_0[SRC_TABLE[i].bit_pos] <= enable_reg[i];
                    end
                    2'd1: begin
                        irq_flag_word_1[SRC_TABLE[i].bit_pos]   <= flag_reg[i];
                        irq_enable_word_1[SRC_TABLE[i].bit_pos] <= enable_reg[i];
                    end
                    2'd2: begin
                        irq_flag_word_2[SRC_TABLE[i].bit_pos]   <= flag_reg[i];
                        irq_enable_word_2[SRC_TABLE[i].bit_pos] <= enable_reg[i];
                    end
                    default: begin
                        irq_flag_word_3[SRC_TABLE[i].bit_pos]   <= flag_reg[i];
                        irq_enable_word_3[SRC_TABLE[i].bit_pos] <= enable_reg[i];
                    end
                endcase
            end
        end
    end

    // Vector address is two per vector above the base of the table
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_req   <= '0;
            shown_idx <= '0;
        end else begin
            // An ack clears the source the core was shown, not a newer winner
            shown_idx        <= win;
            irq_req.valid    <= found && !irq_ack;
            irq_req.level    <= win_level;
            irq_req.vec_num  <= SRC_TABLE[win].vec_num;
            irq_req.irq_num  <= SRC_TABLE[win].irq_num;
            irq_req.vec_addr <= VEC_BASE + {16'h0000, SRC_TABLE[win].vec_num, 1'b0};
        end
    end

    // Fetch counter: even only, moves by two, loads forced to the low word
    always_comb begin
        pc_next = program_counter;
        if (fetch_load) begin
            pc_next = {fetch_target[23:1], 1'b0};
        end else if (fetch_step) begin
            pc_next = program_counter + PC_STEP;
        end else if (fetch_back) begin
            pc_next = program_counter - PC_STEP;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            program_counter <= RESET_PC;
            fetch_upper     <= 1'b0;
            code_in_vectors <= 1'b0;
        end else begin
            program_counter <= pc_next;
            fetch_upper     <= 1'b0;
            code_in_vectors <= fetch_load && ({fetch_target[23:1], 1'b0} < VEC_END)
                               && ({fetch_target[23:1], 1'b0} != START_WORD);
        end
    end

    pc_even_a: assert property (@(posedge clk) disable iff (!reset_n)
        program_counter[0] == 1'b0) else $error("fetch address odd");
    pc_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        fetch_step && !fetch_load |=> program_counter == $past(program_counter) + PC_STEP)
        else $error("fetch step not two");
    pc_reset_a: assert property (@(posedge clk)
        !reset_n |-> program_counter == RESET_PC) else $error("reset fetch not zero");
    evt_sets_a: assert property (@(posedge clk) disable iff (!reset_n)
        src_evt[0] |=> flag_reg[0]) else $error("event lost");
    no_req_a: assert property (@(posedge clk) disable iff (!reset_n)
        (pend == '0) |=> !irq_req.valid) else $error("request without pending");
    vec_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
        irq_req.valid |-> irq_req.vec_addr == VEC_BASE + 24'(2 * irq_req.vec_num))
        else $error("vector address mismatch");
    tie_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        pend[0] && pend[1] && level_reg[2:0] == level_reg[5:3] && level_reg[2:0] != 3'h0
        |-> win == 4'h0) else $error("tie not lower vector");
    tie_vec_a: assert property (@(posedge clk) disable iff (!reset_n)
        pend[15] && pend[5] && level_reg[47:45] == level_reg[17:15]
        |-> win != 4'h5) else $error("tie not vector order");
    can_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        !HAS_CAN |-> !pend[9] && !pend[10]) else $error("absent source pending");
    vec_range_a: assert property (@(posedge clk) disable iff (!reset_n)
        irq_req.valid |-> irq_req.vec_addr < VEC_END) else $error("vector outside region");
    irq_map_a: assert property (@(posedge clk) disable iff (!reset_n)
        irq_req.valid |-> irq_req.vec_num == irq_req.irq_num + IRQ_OFFSET)
        else $error("irq number mismatch");
endmodule // vector_map
`default_nettype wire

/* File: dv/periph_core_model.sv */
/*
 Far-side model: peripherals that pulse their event lines and a core that takes vectors.
 Assumes the bench asks for events through fire and for acknowledges through take.
*/
`default_nettype none
module periph_core_model
    import vector_map_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [N_SRC-1:0] fire,
    input  wire logic             take,
    input  wire irq_req_t         irq_req,
    output logic [N_SRC-1:0]      src_evt,
    output logic                  irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    // Ack never two cycles in a row, but a take held on also acks the next winner once it requests
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_evt <= '0;
            irq_ack <= 1'b0;
        end else begin
            src_evt <= fire;
            irq_ack <= take & irq_req.valid & ~irq_ack;
        end
    end
endmodule // periph_core_model
`default_nettype wire

/* File: dv/tb_top.sv */
/*
 Self-checking bench for the vector mapping block.
 Assumes the design package and the far-side model are compiled first.
*/
`default_nettype none
module tb_top
    import vector_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n, flag_wr, enable_wr, prio_wr, take, fetch_step, fetch_back, fetch_load;
    logic [1:0]       flag_wr_word, enable_wr_word;
    logic [15:0]      flag_wr_data, enable_wr_data;
    logic [3:0]       prio_wr_idx;
    logic [2:0]       prio_wr_level;
    logic [23:0]      fetch_target, pc;
    logic [N_SRC-1:0] fire, src_evt;
    logic             irq_ack, fetch_upper, code_in_vectors;
    logic [15:0]      flag_w [4];
    logic [15:0]      en_w [4];
    irq_req_t         irq_req;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Expected map per checked source: table index, vector, irq, word, bit
    localparam int IX [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 11, 12, 14};
    localparam int EV [13] = '{8, 10, 12, 24, 26, 32, 37, 39, 41, 42, 46, 57, 65};
    localparam int EI [13] = '{0, 2, 4, 16, 18, 24, 29, 31, 33, 34, 38, 49, 57};
    localparam int EW [13] = '{0, 0, 0, 1, 1, 1, 1, 1, 2, 2, 2, 3, 3};
    localparam int EB [13] = '{0, 2, 4, 0, 2, 8, 13, 15, 1, 2, 6, 1, 9};
    localparam logic [15:0] EF [4] = '{16'h0015, 16'ha115, 16'h004e, 16'h0206};

    vector_map DUT (.clk(clk), .reset_n(reset_n), .src_evt(src_evt), .flag_wr(flag_wr),
        .flag_wr_word(flag_wr_word), .flag_wr_data(flag_wr_data), .enable_wr(enable_wr),
        .enable_wr_word(enable_wr_word), .enable_wr_data(enable_wr_data), .prio_wr(prio_wr),
        .prio_wr_idx(prio_wr_idx), .prio_wr_level(prio_wr_level), .irq_ack(irq_ack),
        .fetch_step(fetch_step), .fetch_back(fetch_back), .fetch_load(fetch_load),
        .fetch_target(fetch_target), .irq_flag_word_0(flag_w[0]), .irq_flag_word_1(flag_w[1]),
        .irq_flag_word_2(flag_w[2]), .irq_flag_word_3(flag_w[3]), .irq_enable_word_0(en_w[0]),
        .irq_enable_word_1(en_w[1]), .irq_enable_word_2(en_w[2]), .irq_enable_word_3(en_w[3]),
        .irq_req(irq_req), .program_counter(pc), .fetch_upper(fetch_upper),
        .code_in_vectors(code_in_vectors));
    periph_core_model partner (.clk(clk), .reset_n(reset_n), .fire(fire), .take(take),
        .irq_req(irq_req), .src_evt(src_evt), .irq_ack(irq_ack));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input bit en, input logic [1:0] w, input logic [15:0] d);
        @(posedge clk);
        if (en) begin
            enable_wr <= 1'b1;
            enable_wr_word <= w;
            enable_wr_data <= d;
        end else begin
            flag_wr <= 1'b1;
            flag_wr_word <= w;
            flag_wr_data <= d;
        end
        @(posedge clk);
        flag_wr <= 1'b0;
        enable_wr <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic prio(input logic [3:0] i, input logic [2:0] l);
        @(posedge clk);
        prio_wr <= 1'b1;
        prio_wr_idx <= i;
        prio_wr_level <= l;
        @(posedge clk);
        prio_wr <= 1'b0;
    endtask
    task automatic evt(input logic [15:0] m);
        @(posedge clk);
        fire <= m;
        @(posedge clk);
        fire <= '0;
    endtask
    // Bounded wait, so a source that never requests shows as a mismatch, not a hang
    task automatic wait_req;
        int n;
        n = 0;
        while (irq_req.valid !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        cmpb(irq_req.valid, 1'b1);
    endtask
    task automatic req(input int v, input int q);
        cmp(24'(irq_req.vec_num), 24'(v));
        cmp(24'(irq_req.irq_num), 24'(q));
        cmp(irq_req.vec_addr, 24'(4 + 2 * v));
    endtask
    task automatic ack;
        int n;
        @(posedge clk);
        take <= 1'b1;
        n = 0;
        while (irq_ack !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        take <= 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic fet(input logic s, input logic b, input logic l, input logic [23:0] t);
        @(posedge clk);
        fetch_step <= s;
        fetch_back <= b;
        fetch_load <= l;
        fetch_target <= t;
        @(posedge clk);
        fetch_step <= 1'b0;
        fetch_back <= 1'b0;
        fetch_load <= 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {reset_n, flag_wr, enable_wr, prio_wr, take, fetch_step, fetch_back, fetch_load} = '0;
        {flag_wr_word, enable_wr_word, flag_wr_data, enable_wr_data} = '0;
        {prio_wr_idx, prio_wr_level, fetch_target, fire} = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        cmp(pc, 24'h000000);
        cmpb(irq_req.valid, 1'b0);
        for (int w = 0; w < 4; w++) begin
            wr(1'b1, 2'(w), 16'hffff);
            cmp(24'(en_w[w]), 24'(EF[w]));
        end
        for (int i = 0; i < 13; i++) begin
            evt(16'h0001 << IX[i]);
            wait_req();
            req(EV[i], EI[i]);
            cmpb(flag_w[EW[i]][EB[i]], 1'b1);
            ack();
            cmpb(flag_w[EW[i]][EB[i]], 1'b0);
        end
        evt(16'h0003);
        wait_req();
        req(8, 0);
        ack();
        wait_req();
        req(10, 2);
        ack();
        // The last table entry has a lower vector than several earlier ones
        evt(16'h8020);
        wait_req();
        req(28, 20);
        ack();
        wait_req();
        req(32, 24);
        ack();
        prio(4'h1, 3'h7);
        evt(16'h0003);
        wait_req();
        cmp(24'(irq_req.level), 24'h000007);
        req(10, 2);
        ack();
        wait_req();
        req(8, 0);
        ack();
        // Level zero holds the request back while the flag stays pending
        prio(4'h0, 3'h0);
        evt(16'h0001);
        repeat (4) @(negedge clk);
        cmpb(flag_w[0][0], 1'b1);
        cmpb(irq_req.valid, 1'b0);
        prio(4'h0, 3'h4);
        wait_req();
        req(8, 0);
        ack();
        wr(1'b1, 2'h0, 16'h0000);
        evt(16'h0001);
        repeat (4) @(negedge clk);
        cmpb(flag_w[0][0], 1'b1);
        cmpb(irq_req.valid, 1'b0);
        for (int w = 0; w < 4; w++) begin
            wr(1'b0, 2'(w), 16'hffff);
            cmp(24'(flag_w[w]), 24'(EF[w]));
            wr(1'b0, 2'(w), 16'h0000);
        end
        fet(1'b1, 1'b0, 1'b0, 24'h0);
        cmp(pc, 24'h000002);
        fet(1'b1, 1'b1, 1'b0, 24'h0);
        cmp(pc, 24'h000004);
        fet(1'b0, 1'b1, 1'b0, 24'h0);
        cmp(pc, 24'h000002);
        fet(1'b1, 1'b0, 1'b1, 24'h000100);
        cmp(pc, 24'h000100);
        cmpb(code_in_vectors, 1'b1);
        fet(1'b0, 1'b0, 1'b1, 24'h000400);
        cmpb(code_in_vectors, 1'b0);
        cmpb(fetch_upper, 1'b0);
        fet(1'b1, 1'b0, 1'b0, 24'h0);
        cmp(pc, 24'h000402);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
